// file: smc_misc_ctrl.sv
`timescale 1ns/100ps
module smc_misc_ctrl
  import smc_pkg::*;
#(
  parameter logic WDG_MASK_OPTION = 1'h1
)
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        ce,
  // Reset cause and CPU state
  input  wire logic        power_on_reset,
  input  wire logic        cpu_irq_mask,
  input  wire logic        stop_entry,
  input  wire logic        wait_state,
  input  wire logic        nvm_op_active,
  input  wire logic        irq_pin_n,
  // AXI4-Lite slave
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Block outputs
  output smc_ctrl_t        ctrl,
  output smc_sens_t        irq_sensitivity,
  output logic [12:0]      pulse_a_period,
  output logic [12:0]      pulse_b_period,
  output logic             bus_clk_tick,
  output logic             watchdog_reload,
  output logic             ext_irq_event,
  output logic             nvm_pump_run,
  output logic             irq
);

  // ****************************************************************
  // Register state
  // ****************************************************************
  logic             por_flag_reg;
  logic             irq_positive_select_reg;
  logic             irq_negative_select_reg;
  logic             ext_interrupt_enable_reg;
  logic             sfa_reg;
  logic             sfb_reg;
  logic             sm_reg;
  logic             wdg_reg;
  logic             wdg_reload_reg;
  logic [SMC_EV_W-1:0] ev_stat_reg;
  logic [SMC_EV_W-1:0] ev_mask_reg;
  logic             por_seen_reg;

  // Bus channel state
  logic             aw_hold_reg;
  logic             w_hold_reg;
  logic [11:0]      awaddr_reg;
  logic [31:0]      wdata_reg;
  logic [3:0]       wstrb_reg;
  logic             bvalid_reg;
  logic [1:0]       bresp_reg;
  logic             rvalid_reg;
  logic [31:0]      rdata_reg;
  logic [1:0]       rresp_reg;

  // Irq pin synchroniser and edge history
  logic             irq_meta_reg;
  logic             irq_sync_reg;
  logic             irq_prev_reg;
  logic             ext_irq_event_reg;

  logic             wr_fire;
  logic             wr_misc;
  logic             wr_stat;
  logic             wr_mask;
  logic             wr_lane0;
  logic [7:0]       wbyte;
  logic             rd_fire;
  logic [SMC_EV_W-1:0] ev_set;
  logic [7:0]       misc_rd;

  // ****************************************************************
  // AXI4-Lite write path
  // ****************************************************************
  // Readies drop with ce so no beat is accepted while state is frozen
  assign s_axi_awready = ce && !aw_hold_reg && !bvalid_reg;
  assign s_axi_wready  = ce && !w_hold_reg && !bvalid_reg;

  // Address and data are latched independently, in either order
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_hold_reg <= 1'b0;
      w_hold_reg  <= 1'b0;
      awaddr_reg  <= 12'h000;
      wdata_reg   <= 32'h0000_0000;
      wstrb_reg   <= 4'h0;
    end
    else if (ce)
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_hold_reg <= 1'b1;
        awaddr_reg  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_hold_reg <= 1'b1;
        wdata_reg  <= s_axi_wdata;
        wstrb_reg  <= s_axi_wstrb;
      end
      if (wr_fire)
      begin
        aw_hold_reg <= 1'b0;
        w_hold_reg  <= 1'b0;
      end
    end
  end

  assign wr_fire  = ce && aw_hold_reg && w_hold_reg && !bvalid_reg;
  assign wr_lane0 = wstrb_reg[0];
  assign wbyte    = wdata_reg[7:0];
  assign wr_misc  = wr_fire && wr_lane0 &&
                    (awaddr_reg[11:2] == SMC_MISC_OFFS[11:2]);
  assign wr_stat  = wr_fire && wr_lane0 &&
                    (awaddr_reg[11:2] == SMC_IRQ_STAT[11:2]);
  assign wr_mask  = wr_fire && wr_lane0 &&
                    (awaddr_reg[11:2] == SMC_IRQ_MASK[11:2]);

  // Response; unmapped addresses answer SLVERR
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= SMC_RESP_OKAY;
    end
    else if (ce)
    begin
      if (wr_fire)
      begin
        bvalid_reg <= 1'b1;
        bresp_reg  <= (awaddr_reg[11:2] == SMC_MISC_OFFS[11:2] ||
                       awaddr_reg[11:2] == SMC_IRQ_STAT[11:2] ||
                       awaddr_reg[11:2] == SMC_IRQ_MASK[11:2])
                      ? SMC_RESP_OKAY : SMC_RESP_SLVERR;
      end
      else if (s_axi_bready)
        bvalid_reg <= 1'b0;
    end
  end

  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp  = bresp_reg;

  // ****************************************************************
  // Control register fields
  // ****************************************************************

  // Power-on flag: hardware sets, software only clears by writing 0
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      por_seen_reg <= 1'b0;
    else if (ce)
      por_seen_reg <= power_on_reset;
  end

  // Flag caught after release so reset takes only a constant
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      por_flag_reg <= 1'b0;
    else if (ce)
    begin
      if (power_on_reset && !por_seen_reg)
        por_flag_reg <= 1'b1;
      else if (wr_misc && !wbyte[SMC_POR_BIT])
        por_flag_reg <= 1'b0;
    end
  end

  // Sensitivity and enable only change while CPU masks interrupts
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      irq_positive_select_reg <= 1'b0;
      irq_negative_select_reg <= 1'b0;
      ext_interrupt_enable_reg <= SMC_EXT_INTERRUPT_ENABLE_RST;
    end
    else if (ce && wr_misc && cpu_irq_mask)
    begin
      irq_positive_select_reg <= wbyte[SMC_IRQ_POSITIVE_SELECT_BIT];
      irq_negative_select_reg <= wbyte[SMC_IRQ_NEGATIVE_SELECT_BIT];
      ext_interrupt_enable_reg <= wbyte[SMC_EXT_INTERRUPT_ENABLE_BIT];
    end
  end

  // Period selects take effect at once; there is no shadow copy
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sfa_reg <= 1'b0;
      sfb_reg <= 1'b0;
    end
    else if (ce && wr_misc)
    begin
      sfa_reg <= wbyte[SMC_SFA_BIT];
      sfb_reg <= wbyte[SMC_SFB_BIT];
    end
  end

  // Stop entry beats a same-cycle write so the bus never stays slow
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      sm_reg <= 1'b0;
    else if (ce)
    begin
      if (stop_entry)
        sm_reg <= 1'b0;
      else if (wr_misc)
        sm_reg <= wbyte[SMC_SM_BIT];
    end
  end

  // Watchdog bit: reset to mask option, only writable to one
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      wdg_reg        <= WDG_MASK_OPTION;
      wdg_reload_reg <= 1'b0;
    end
    else if (ce)
    begin
      wdg_reload_reg <= wr_misc && wbyte[SMC_WDG_BIT];
      if (wr_misc && wbyte[SMC_WDG_BIT])
        wdg_reg <= 1'b1;
    end
  end

  // ****************************************************************
  // Derived behaviour
  // ****************************************************************
  assign pulse_a_period = sfa_reg ? SMC_PERIOD_SLOW : SMC_PERIOD_FAST;
  assign pulse_b_period = sfb_reg ? SMC_PERIOD_SLOW : SMC_PERIOD_FAST;
  assign irq_sensitivity = smc_sens_t'({irq_positive_select_reg, irq_negative_select_reg});

  // Bus tick every 2 or 32 cycles of the oscillator clock
  smc_divider #(
    .W (5)
  ) u_bus_div (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    .limit   (sm_reg ? SMC_DIV_SLOW : SMC_DIV_NORMAL),
    .tick    (bus_clk_tick)
  );

  // Wait does not stop the pump; only the stop request does
  assign nvm_pump_run = nvm_op_active && !stop_entry;

  // Irq pin: two flops, then edge and level detect
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      irq_meta_reg      <= 1'b1;
      irq_sync_reg      <= 1'b1;
      irq_prev_reg      <= 1'b1;
      ext_irq_event_reg <= 1'b0;
    end
    else if (ce)
    begin
      irq_meta_reg <= irq_pin_n;
      irq_sync_reg <= irq_meta_reg;
      irq_prev_reg <= irq_sync_reg;
      case (irq_sensitivity)
        SMC_SENS_LOW_FALL:
          ext_irq_event_reg <= ext_interrupt_enable_reg && !irq_sync_reg;
        SMC_SENS_FALL:
          ext_irq_event_reg <= ext_interrupt_enable_reg && irq_prev_reg && !irq_sync_reg;
        SMC_SENS_RISE:
          ext_irq_event_reg <= ext_interrupt_enable_reg && !irq_prev_reg && irq_sync_reg;
        SMC_SENS_BOTH:
          ext_irq_event_reg <= ext_interrupt_enable_reg && (irq_prev_reg != irq_sync_reg);
        default:
          ext_irq_event_reg <= 1'b0;
      endcase
    end
  end

  // ****************************************************************
  // Event status and interrupt
  // ****************************************************************
  always_comb
  begin
    ev_set = '0;
    ev_set[SMC_EV_WDG_REFRESH] = wr_misc && wbyte[SMC_WDG_BIT];
    ev_set[SMC_EV_STOP_CLEAR]  = stop_entry && sm_reg;
    ev_set[SMC_EV_BLOCKED_WR]  = wr_misc && !cpu_irq_mask;
  end

  // Set wins over a write-one clear in the same cycle
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ev_stat_reg <= SMC_EV_RST;
      ev_mask_reg <= SMC_EV_RST;
    end
    else if (ce)
    begin
      ev_stat_reg <= (ev_stat_reg &
                      ~(wr_stat ? wbyte[SMC_EV_W-1:0] : '0)) | ev_set;
      if (wr_mask)
        ev_mask_reg <= wbyte[SMC_EV_W-1:0];
    end
  end

  assign irq = |(ev_stat_reg & ev_mask_reg);

  // ****************************************************************
  // AXI4-Lite read path
  // ****************************************************************
  assign misc_rd = {por_flag_reg, irq_positive_select_reg, irq_negative_select_reg, ext_interrupt_enable_reg,
                    sfa_reg, sfb_reg, sm_reg, wdg_reg};
  assign s_axi_arready = ce && !rvalid_reg;
  assign rd_fire = ce && s_axi_arvalid && s_axi_arready;

  // One-cycle read latency; unmapped reads return zero with SLVERR
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= 32'h0000_0000;
      rresp_reg  <= SMC_RESP_OKAY;
    end
    else if (ce)
    begin
      if (rd_fire)
      begin
        rvalid_reg <= 1'b1;
        rresp_reg  <= SMC_RESP_OKAY;
        case (s_axi_araddr[11:2])
          SMC_MISC_OFFS[11:2]: rdata_reg <= {24'h000000, misc_rd};
          SMC_IRQ_STAT[11:2]:  rdata_reg <= {29'h0, ev_stat_reg};
          SMC_IRQ_MASK[11:2]:  rdata_reg <= {29'h0, ev_mask_reg};
          default:
          begin
            rdata_reg <= 32'h0000_0000;
            rresp_reg <= SMC_RESP_SLVERR;
          end
        endcase
      end
      else if (s_axi_rready)
        rvalid_reg <= 1'b0;
    end
  end

  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata  = rdata_reg;
  assign s_axi_rresp  = rresp_reg;

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign ctrl = '{irq_positive_select:     irq_positive_select_reg,
                  irq_negative_select:     irq_negative_select_reg,
                  ext_interrupt_enable:    ext_interrupt_enable_reg,
                  pulse_a_period_select:   sfa_reg,
                  pulse_b_period_select:   sfb_reg,
                  bus_slow_mode:           sm_reg,
                  watchdog_enable_refresh: wdg_reg};
  assign watchdog_reload = wdg_reload_reg;
  assign ext_irq_event   = ext_irq_event_reg;

  // Unused wait input kept: wait leaves every field untouched
  logic unused_wait;
  assign unused_wait = wait_state;

endmodule : smc_misc_ctrl

// file: smc_pkg.sv
// Behaviour
// - Program or erase and its charge pump keep running unchanged during wait.
// - Power-on flag set by power-on reset only, cleared by writing zero.
// - Two sensitivity bits pick low level, falling, rising or both edges.
// - Sensitivity writes need CPU interrupt mask set; reset clears both bits.
// - Interrupt enable bit writable only with mask set; reset sets it.
// - Pulse A period is 4096 timer clocks when set, 256 when clear.
// - Pulse B period is 4096 timer clocks when set, 256 when clear.
// - Slow mode divides bus clock by 32 instead of 2.
// - Slow mode cleared by reset and on entering stop.
// - Writing one enables and reloads watchdog; writing zero does nothing.
// - After any reset the watchdog bit takes the mask option value.
package smc_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [11:0] SMC_MISC_OFFS   = 12'h00c;
  localparam logic [11:0] SMC_IRQ_STAT    = 12'h010;
  localparam logic [11:0] SMC_IRQ_MASK    = 12'h014;

  // Field positions in the control register
  localparam int SMC_POR_BIT  = 7;
  localparam int SMC_IRQ_POSITIVE_SELECT_BIT = 6;
  localparam int SMC_IRQ_NEGATIVE_SELECT_BIT = 5;
  localparam int SMC_EXT_INTERRUPT_ENABLE_BIT = 4;
  localparam int SMC_SFA_BIT  = 3;
  localparam int SMC_SFB_BIT  = 2;
  localparam int SMC_SM_BIT   = 1;
  localparam int SMC_WDG_BIT  = 0;

  // Event bits in the status and mask registers
  localparam int SMC_EV_WDG_REFRESH = 0;
  localparam int SMC_EV_STOP_CLEAR  = 1;
  localparam int SMC_EV_BLOCKED_WR  = 2;
  localparam int SMC_EV_W           = 3;

  // Reset values
  localparam logic       SMC_EXT_INTERRUPT_ENABLE_RST = 1'h1;
  localparam logic [2:0] SMC_EV_RST   = 3'h0;

  // Timing counts
  localparam logic [12:0] SMC_PERIOD_SLOW = 13'h1000;
  localparam logic [12:0] SMC_PERIOD_FAST = 13'h0100;
  localparam logic [4:0]  SMC_DIV_SLOW    = 5'h1f;
  localparam logic [4:0]  SMC_DIV_NORMAL  = 5'h01;

  localparam logic [1:0] SMC_RESP_OKAY   = 2'h0;
  localparam logic [1:0] SMC_RESP_SLVERR = 2'h2;

  // Irq sensitivity decoded from the two select bits
  typedef enum logic [1:0] {
    SMC_SENS_LOW_FALL = 2'h0,
    SMC_SENS_FALL     = 2'h1,
    SMC_SENS_RISE     = 2'h2,
    SMC_SENS_BOTH     = 2'h3
  } smc_sens_t;

  // Control fields driven out of the block
  typedef struct packed {
    logic       irq_positive_select;
    logic       irq_negative_select;
    logic       ext_interrupt_enable;
    logic       pulse_a_period_select;
    logic       pulse_b_period_select;
    logic       bus_slow_mode;
    logic       watchdog_enable_refresh;
  } smc_ctrl_t;

endpackage : smc_pkg

// file: smc_divider.sv
`timescale 1ns/100ps
// Programmable divider giving a one-cycle tick every limit+1 enabled cycles
module smc_divider
  import smc_pkg::*;
#(
  parameter int W = 5
)
(
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic         ce,
  input  wire logic [W-1:0] limit,
  output logic              tick
);

  logic [W-1:0] cnt_reg;

  // Count up, wrap at limit; a lowered limit wraps at once
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      cnt_reg <= '0;
    else if (ce)
    begin
      if (cnt_reg >= limit)
        cnt_reg <= '0;
      else
        cnt_reg <= cnt_reg + 1'b1;
    end
  end

  assign tick = ce && (cnt_reg >= limit);

endmodule : smc_divider

// file: smc_misc_ctrl_properties.sv
`timescale 1ns/100ps
module smc_misc_ctrl_props
  import smc_pkg::*;
(
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        ce,
  input wire logic        cpu_irq_mask,
  input wire logic        stop_entry,
  input wire logic        nvm_op_active,
  input wire smc_ctrl_t   ctrl,
  input wire smc_sens_t   irq_sensitivity,
  input wire logic [12:0] pulse_a_period,
  input wire logic [12:0] pulse_b_period,
  input wire logic        bus_clk_tick,
  input wire logic        watchdog_reload,
  input wire logic        nvm_pump_run
);
  // ****************************************************************
  // Properties
  // ****************************************************************
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // Pump ignores wait, only stop may cut it
  a_pump_follows : assert property (
    nvm_pump_run == (nvm_op_active && !stop_entry))
    else $error("pump run does not follow program state");
  a_sens_decode : assert property (
    irq_sensitivity == {ctrl.irq_positive_select, ctrl.irq_negative_select})
    else $error("sensitivity does not match select bits");
  // A write that lands while the mask is clear must leave the bits alone
  a_mask_guards : assert property (
    !cpu_irq_mask |=> $stable(irq_sensitivity)
      && $stable(ctrl.ext_interrupt_enable))
    else $error("irq bits changed with mask clear");
  a_period_a : assert property (
    pulse_a_period == (ctrl.pulse_a_period_select ? 13'h1000 : 13'h0100))
    else $error("pulse a period wrong");
  a_period_b : assert property (
    pulse_b_period == (ctrl.pulse_b_period_select ? 13'h1000 : 13'h0100))
    else $error("pulse b period wrong");
  a_fast_tick : assert property (
    ce && bus_clk_tick && !ctrl.bus_slow_mode
      |=> !bus_clk_tick ##1 (bus_clk_tick || ctrl.bus_slow_mode))
    else $error("normal bus tick not every second cycle");
  // Only the first eight cycles of the slow gap; the bench times the rest
  a_slow_gap : assert property (
    ce && bus_clk_tick && ctrl.bus_slow_mode
      |=> (!bus_clk_tick || !ctrl.bus_slow_mode)[*8])
    else $error("slow bus tick too early");
  a_stop_clears : assert property (
    ce && stop_entry |=> !ctrl.bus_slow_mode)
    else $error("slow mode survived stop");
  a_reload_pulse : assert property (
    watchdog_reload |-> ctrl.watchdog_enable_refresh ##1 !watchdog_reload)
    else $error("reload pulse without enable or too long");

  c_slow_tick : cover property (bus_clk_tick && ctrl.bus_slow_mode);
  c_reload : cover property (watchdog_reload);
  c_both_edges : cover property (irq_sensitivity == SMC_SENS_BOTH);
endmodule : smc_misc_ctrl_props

// file: smc_misc_ctrl_bench.sv
`timescale 1ns/100ps
module smc_misc_ctrl_bench
  import smc_pkg::*;
;
  logic        aclk, aresetn, ce, power_on_reset, cpu_irq_mask;
  logic        stop_entry, wait_state, nvm_op_active, irq_pin_n;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  smc_ctrl_t   ctrl;
  smc_sens_t   irq_sensitivity;
  logic [12:0] pulse_a_period, pulse_b_period;
  logic        bus_clk_tick, watchdog_reload, ext_irq_event;
  logic        nvm_pump_run, irq;
  int          err_total, checked, reloads, n_ev;

  // Clock, 4 ns period
  always #2 aclk = ~aclk;

  // Mask option off so a software enable is visible
  smc_misc_ctrl #(.WDG_MASK_OPTION(1'h0)) dut_u (
    .aclk, .aresetn, .ce, .power_on_reset, .cpu_irq_mask, .stop_entry,
    .wait_state, .nvm_op_active, .irq_pin_n, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ctrl,
    .irq_sensitivity, .pulse_a_period, .pulse_b_period, .bus_clk_tick,
    .watchdog_reload, .ext_irq_event, .nvm_pump_run, .irq);

  // Count reload pulses seen at clock edges
  always @(posedge aclk)
    if (watchdog_reload === 1'b1)
      reloads++;

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic summarize();
    $display("Checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : summarize

  task automatic check(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      err_total++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  // One clock with a bound, so no wait can hang the run
  task automatic step(inout int k);
    @(posedge aclk);
    k++;
    if (k > 200)
    begin
      err_total++;
      summarize();
    end
  endtask : step

  task automatic wr(input logic [11:0] a, input logic [7:0] d,
                    input logic [1:0] er = SMC_RESP_OKAY);
    int k;
    k = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      step(k);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end
    while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    check("bresp", {30'h0, s_axi_bresp}, {30'h0, er});
  endtask : wr

  task automatic rdc(input logic [11:0] a, input logic [7:0] exp,
                     input logic [1:0] er = SMC_RESP_OKAY);
    int k;
    k = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      step(k);
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end
    while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    check("rdata", s_axi_rdata, {24'h0, exp});
    check("rresp", {30'h0, s_axi_rresp}, {30'h0, er});
  endtask : rdc

  // Count pin event pulses over a fixed window of clocks
  task automatic count_ev(input int n, output int c);
    c = 0;
    repeat (n)
    begin
      @(posedge aclk);
      if (ext_irq_event === 1'b1)
        c++;
    end
  endtask : count_ev

  // Cycles from one bus tick to the next
  task automatic gap(input int exp);
    int k;
    int g;
    k = 0;
    g = 0;
    do step(k); while (bus_clk_tick !== 1'b1);
    do
    begin
      step(k);
      g++;
    end
    while (bus_clk_tick !== 1'b1);
    check("tick_gap", g, exp);
  endtask : gap

  // ****************************************************************
  // Sequence
  // ****************************************************************
  initial
  begin
    {aclk, aresetn, power_on_reset, cpu_irq_mask, stop_entry} = 5'h00;
    {wait_state, nvm_op_active, s_axi_awvalid, s_axi_wvalid} = 4'h0;
    {s_axi_bready, s_axi_arvalid, s_axi_rready} = 3'h0;
    {ce, irq_pin_n} = 2'h3;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 56'h0;
    s_axi_wstrb = 4'hf;
    {err_total, checked, reloads} = 96'h0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    rdc(SMC_MISC_OFFS, 8'h10);
    rdc(SMC_IRQ_STAT, 8'h00);
    power_on_reset <= 1'b1;
    repeat (3) @(posedge aclk);
    power_on_reset <= 1'b0;
    cpu_irq_mask <= 1'b1;
    rdc(SMC_MISC_OFFS, 8'h90);
    wr(SMC_MISC_OFFS, 8'h10);
    rdc(SMC_MISC_OFFS, 8'h10);
    wr(SMC_MISC_OFFS, 8'h90);
    rdc(SMC_MISC_OFFS, 8'h10);
    // Every sensitivity code, written with the mask set
    for (int s = 0; s < 4; s++)
    begin
      wr(SMC_MISC_OFFS, {1'b0, s[1:0], 5'h10});
      rdc(SMC_MISC_OFFS, {1'b0, s[1:0], 5'h10});
      check("sens", {30'h0, irq_sensitivity}, {30'h0, s[1:0]});
    end
    // Blocked write raises a status bit, masked, then unmasked, cleared
    cpu_irq_mask <= 1'b0;
    wr(SMC_MISC_OFFS, 8'h00);
    rdc(SMC_MISC_OFFS, 8'h70);
    rdc(SMC_IRQ_STAT, 8'h04);
    check("irq_masked", {31'h0, irq}, 32'h0);
    wr(SMC_IRQ_MASK, 8'h04);
    rdc(SMC_IRQ_MASK, 8'h04);
    check("irq_set", {31'h0, irq}, 32'h1);
    wr(SMC_IRQ_STAT, 8'h04);
    rdc(SMC_IRQ_STAT, 8'h00);
    check("irq_clr", {31'h0, irq}, 32'h0);
    cpu_irq_mask <= 1'b1;
    wr(SMC_MISC_OFFS, 8'h00);
    rdc(SMC_MISC_OFFS, 8'h00);
    for (int p = 0; p < 4; p++)
    begin
      wr(SMC_MISC_OFFS, {4'h0, p[1:0], 2'h0});
      check("pa", {19'h0, pulse_a_period}, p[1] ? 32'h1000 : 32'h100);
      check("pb", {19'h0, pulse_b_period}, p[0] ? 32'h1000 : 32'h100);
    end
    gap(2);
    wr(SMC_MISC_OFFS, 8'h02);
    gap(32);
    // Program runs through wait; stop ends it and slow mode
    nvm_op_active <= 1'b1;
    wait_state <= 1'b1;
    @(posedge aclk);
    stop_entry <= 1'b1;
    check("pump_wait", {31'h0, nvm_pump_run}, 32'h1);
    @(posedge aclk);
    stop_entry <= 1'b0;
    check("pump_stop", {31'h0, nvm_pump_run}, 32'h0);
    rdc(SMC_MISC_OFFS, 8'h00);
    wr(SMC_MISC_OFFS, 8'h01);
    rdc(SMC_MISC_OFFS, 8'h01);
    wr(SMC_MISC_OFFS, 8'h00);
    rdc(SMC_MISC_OFFS, 8'h01);
    check("reloads", reloads, 32'h1);
    rdc(SMC_IRQ_STAT, 8'h03);
    aresetn <= 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    rdc(SMC_MISC_OFFS, 8'h10);
    rdc(12'h020, 8'h00, SMC_RESP_SLVERR);
    wr(12'h020, 8'h55, SMC_RESP_SLVERR);
    irq_pin_n <= 1'b0;
    repeat (6) @(posedge aclk);
    check("ext_irq", {31'h0, ext_irq_event}, 32'h1);
    irq_pin_n <= 1'b1;
    // Rising edge only: a fall gives nothing, a rise one pulse
    wr(SMC_MISC_OFFS, 8'h50);
    irq_pin_n <= 1'b0;
    count_ev(8, n_ev);
    check("rise_on_fall", n_ev, 32'h0);
    irq_pin_n <= 1'b1;
    count_ev(8, n_ev);
    check("rise_on_rise", n_ev, 32'h1);
    // Both edges: a fall gives one pulse
    wr(SMC_MISC_OFFS, 8'h70);
    irq_pin_n <= 1'b0;
    count_ev(8, n_ev);
    check("both_on_fall", n_ev, 32'h1);
    // Falling edge only: a rise gives nothing, a fall one pulse
    wr(SMC_MISC_OFFS, 8'h30);
    irq_pin_n <= 1'b1;
    count_ev(8, n_ev);
    check("fall_on_rise", n_ev, 32'h0);
    irq_pin_n <= 1'b0;
    count_ev(8, n_ev);
    check("fall_on_fall", n_ev, 32'h1);
    // Enable clear: no pulse on either edge
    wr(SMC_MISC_OFFS, 8'h20);
    irq_pin_n <= 1'b1;
    count_ev(8, n_ev);
    check("off_on_rise", n_ev, 32'h0);
    irq_pin_n <= 1'b0;
    count_ev(8, n_ev);
    check("off_on_fall", n_ev, 32'h0);
    irq_pin_n <= 1'b1;
    summarize();
  end
endmodule : smc_misc_ctrl_bench

bind smc_misc_ctrl smc_misc_ctrl_props chk_u (
  .aclk, .aresetn, .ce, .cpu_irq_mask, .stop_entry, .nvm_op_active,
  .ctrl, .irq_sensitivity, .pulse_a_period, .pulse_b_period,
  .bus_clk_tick, .watchdog_reload, .nvm_pump_run);
